/* File: rtl/tcb_top.v */
/*
  Three-channel 16-bit timer/counter block in capture configuration:
  register file, block trigger, external clock line routing, per-channel
  clock control, triggers and capture loads.
  Assumes a single 250 MHz clock; all timer clocks, clock pins and channel
  lines are slow asynchronous levels sampled by this clock.
*/
`include "tcb_map.vh"
`timescale 1ns/1ps
`default_nettype none

module tcb_top (
  // Clock, reset and freeze
  input wire clock,
  input wire rst_b,
  input wire clk_en,
  // Register port
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  // Asynchronous timer inputs
  input wire [4:0] internal_clock,
  input wire [2:0] clock_pin,
  input wire [2:0] channel_line_a,
  input wire [2:0] channel_line_b,
  // Observed state
  output reg [2:0] external_clock_line,
  output reg [2:0] counter_running
);

  // --------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------
  reg [13:0] meta_reg;
  reg [13:0] sync_reg;
  reg [2:0] line_a_prev_reg;
  reg [2:0] line_b_prev_reg;
  wire [4:0] int_clk_s = sync_reg[4:0];
  wire [2:0] pin_s = sync_reg[7:5];
  wire [2:0] line_a_s = sync_reg[10:8];
  wire [2:0] line_b_s = sync_reg[13:11];

  always @(posedge clock) begin
    if (!rst_b) begin
      meta_reg <= 14'h0000;
      sync_reg <= 14'h0000;
      line_a_prev_reg <= 3'h0;
      line_b_prev_reg <= 3'h0;
    end else if (clk_en) begin
      meta_reg <= {channel_line_b, channel_line_a, clock_pin, internal_clock};
      sync_reg <= meta_reg;
      line_a_prev_reg <= line_a_s;
      line_b_prev_reg <= line_b_s;
    end
  end

  // --------------------------------------------------------------------
  // Address decode and block registers
  // --------------------------------------------------------------------
  wire [1:0] ch_sel = addr[7:6];
  wire [5:0] ch_off = addr[5:0];
  wire sync_trig = wr && addr == `TCB_BLOCK_CTRL && wdata[`TCB_BCR_SYNC];
  reg [5:0] block_mode_reg;

  always @(posedge clock) begin
    if (!rst_b) begin
      block_mode_reg <= `TCB_BMR_RESET;
    end else if (clk_en && wr && addr == `TCB_BLOCK_MODE) begin
      block_mode_reg <= wdata[5:0];
    end
  end

  // In capture mode each channel line A is an input; it is what the
  // neighbouring channels see as that channel's output A.
  always @(posedge clock) begin
    if (!rst_b) begin
      external_clock_line <= 3'h0;
    end else if (clk_en) begin
      case (block_mode_reg[1:0])
        2'h0: external_clock_line[0] <= pin_s[0];
        2'h2: external_clock_line[0] <= line_a_s[1];
        2'h3: external_clock_line[0] <= line_a_s[2];
        default: external_clock_line[0] <= 1'b0;
      endcase
      case (block_mode_reg[3:2])
        2'h0: external_clock_line[1] <= pin_s[1];
        2'h2: external_clock_line[1] <= line_a_s[0];
        2'h3: external_clock_line[1] <= line_a_s[2];
        default: external_clock_line[1] <= 1'b0;
      endcase
      case (block_mode_reg[5:4])
        2'h0: external_clock_line[2] <= pin_s[2];
        2'h2: external_clock_line[2] <= line_a_s[0];
        2'h3: external_clock_line[2] <= line_a_s[1];
        default: external_clock_line[2] <= 1'b0;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Channels
  // --------------------------------------------------------------------
  wire [95:0] mode_w;
  wire [47:0] cv_w;
  wire [47:0] ra_w;
  wire [47:0] rb_w;
  wire [47:0] rc_w;
  wire [23:0] status_w;
  wire [23:0] mask_w;
  wire [2:0] running_w;

  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : gen_ch
      wire hit = ch_sel == i;
      wire wr_hit = wr && hit;
      wire [5:0] off = ch_off;
      reg [31:0] mode_reg;
      reg [15:0] cv_reg;
      reg [15:0] ra_reg;
      reg [15:0] rb_reg;
      reg [15:0] rc_reg;
      reg [7:0] status_reg;
      reg [7:0] mask_reg;
      reg enabled_reg;
      reg stopped_reg;
      reg trig_pend_reg;
      reg a_done_reg;
      reg a_unread_reg;
      reg b_unread_reg;
      reg clk_prev_reg;
      reg clk_raw;
      reg [7:0] st_set;
      wire wave = mode_reg[`TCB_CMR_WAVE];
      wire [2:0] clk_sel = mode_reg[2:0];
      wire [1:0] burst = mode_reg[5:4];
      wire [1:0] etrg_edge = mode_reg[9:8];
      wire [1:0] lda_edge = mode_reg[17:16];
      wire [1:0] ldb_edge = mode_reg[19:18];
      wire gate = (burst == 2'h0) ? 1'b1 : external_clock_line[burst - 2'h1];
      wire clk_lvl = (clk_raw & gate) ^ mode_reg[`TCB_CMR_CLOCK_INVERT];
      wire active = clk_lvl && !clk_prev_reg;
      wire counting = enabled_reg && !stopped_reg;
      wire a_rise = line_a_s[i] && !line_a_prev_reg[i];
      wire a_fall = !line_a_s[i] && line_a_prev_reg[i];
      wire trg_src = mode_reg[`TCB_CMR_EXT_TRIGGER_SOURCE] ? line_a_s[i] : line_b_s[i];
      wire trg_prev = mode_reg[`TCB_CMR_EXT_TRIGGER_SOURCE] ? line_a_prev_reg[i] : line_b_prev_reg[i];
      wire ext_trig = !wave && ((etrg_edge[0] && trg_src && !trg_prev) ||
                                (etrg_edge[1] && !trg_src && trg_prev));
      wire a_edge = (lda_edge[0] && a_rise) || (lda_edge[1] && a_fall);
      wire b_edge = (ldb_edge[0] && a_rise) || (ldb_edge[1] && a_fall);
      wire load_a = !wave && a_edge && !a_done_reg;
      wire load_b = !wave && b_edge && a_done_reg && !load_a;
      wire cmp_hit = active && counting && cv_reg == rc_reg;
      wire cmd_wr = wr_hit && off == `TCB_CH_CMD;
      wire sw_trig = (cmd_wr && wdata[`TCB_CCR_SOFTWARE_TRIGGER_CMD]) || sync_trig;
      wire cmp_trig = cmp_hit && mode_reg[`TCB_CMR_COMPARE_C_TRIGGER];
      wire any_trig = sw_trig || ext_trig || cmp_trig;
      wire st_rd = rd && hit && off == `TCB_CH_STATUS;

      always @* begin
        case (clk_sel)
          3'h0: clk_raw = int_clk_s[0];
          3'h1: clk_raw = int_clk_s[1];
          3'h2: clk_raw = int_clk_s[2];
          3'h3: clk_raw = int_clk_s[3];
          3'h4: clk_raw = int_clk_s[4];
          3'h5: clk_raw = external_clock_line[0];
          3'h6: clk_raw = external_clock_line[1];
          3'h7: clk_raw = external_clock_line[2];
          default: clk_raw = 1'b0;
        endcase
      end

      always @* begin
        st_set = 8'h00;
        st_set[`TCB_ST_OVF] = active && counting && !trig_pend_reg && cv_reg == 16'hFFFF;
        st_set[`TCB_ST_LOVR] = (load_a && a_unread_reg) || (load_b && b_unread_reg);
        st_set[`TCB_ST_CPC] = cmp_hit;
        st_set[`TCB_ST_LDA] = load_a;
        st_set[`TCB_ST_LDB] = load_b;
        st_set[`TCB_ST_ETRG] = ext_trig;
      end

      always @(posedge clock) begin
        if (!rst_b) begin
          mode_reg <= `TCB_CMR_RESET;
          cv_reg <= 16'h0000;
          ra_reg <= 16'h0000;
          rb_reg <= 16'h0000;
          rc_reg <= 16'h0000;
          status_reg <= 8'h00;
          mask_reg <= 8'h00;
          enabled_reg <= 1'b0;
          stopped_reg <= 1'b0;
          trig_pend_reg <= 1'b0;
          a_done_reg <= 1'b0;
          a_unread_reg <= 1'b0;
          b_unread_reg <= 1'b0;
          clk_prev_reg <= 1'b0;
        end else if (clk_en) begin
          clk_prev_reg <= clk_lvl;
          if (wr_hit && off == `TCB_CH_MODE) begin
            mode_reg <= wdata;
          end
          if (wr_hit && off == `TCB_CH_RC) begin
            rc_reg <= wdata[15:0];
          end
          if (wr_hit && off == `TCB_CH_IRQ_EN) begin
            mask_reg <= mask_reg | wdata[7:0];
          end else if (wr_hit && off == `TCB_CH_IRQ_DIS) begin
            mask_reg <= mask_reg & ~wdata[7:0];
          end
          // Flags set in the same cycle as the clearing read survive it.
          status_reg <= (st_rd ? 8'h00 : status_reg) | st_set;
          // Clock control: disable wins over enable, B load disable over all.
          if ((cmd_wr && wdata[`TCB_CCR_CLOCK_DISABLE_CMD]) || (load_b && mode_reg[`TCB_CMR_DISABLE_ON_B_LOAD])) begin
            enabled_reg <= 1'b0;
          end else if (cmd_wr && wdata[`TCB_CCR_CLOCK_ENABLE_CMD]) begin
            enabled_reg <= 1'b1;
          end
          if (load_b && mode_reg[`TCB_CMR_STOP_ON_B_LOAD]) begin
            stopped_reg <= 1'b1;
          end else if (any_trig) begin
            stopped_reg <= 1'b0;
          end
          // A trigger only arms; the reset lands on the next counter clock
          // edge, so the value can read nonzero just after a trigger.
          if (any_trig) begin
            trig_pend_reg <= 1'b1;
          end else if (active) begin
            trig_pend_reg <= 1'b0;
          end
          if (active && trig_pend_reg) begin
            cv_reg <= 16'h0000;
          end else if (active && counting) begin
            cv_reg <= cv_reg + 16'h0001;
          end
          if (any_trig) begin
            a_done_reg <= 1'b0;
          end else if (load_a) begin
            a_done_reg <= 1'b1;
          end else if (load_b) begin
            a_done_reg <= 1'b0;
          end
          if (load_a) begin
            ra_reg <= cv_reg;
            a_unread_reg <= 1'b1;
          end else if (wave && wr_hit && off == `TCB_CH_RA) begin
            ra_reg <= wdata[15:0];
          end else if (rd && hit && off == `TCB_CH_RA) begin
            a_unread_reg <= 1'b0;
          end
          if (load_b) begin
            rb_reg <= cv_reg;
            b_unread_reg <= 1'b1;
          end else if (wave && wr_hit && off == `TCB_CH_RB) begin
            rb_reg <= wdata[15:0];
          end else if (rd && hit && off == `TCB_CH_RB) begin
            b_unread_reg <= 1'b0;
          end
        end
      end

      assign mode_w[32 * i +: 32] = mode_reg;
      assign cv_w[16 * i +: 16] = cv_reg;
      assign ra_w[16 * i +: 16] = ra_reg;
      assign rb_w[16 * i +: 16] = rb_reg;
      assign rc_w[16 * i +: 16] = rc_reg;
      assign status_w[8 * i +: 8] = status_reg;
      assign mask_w[8 * i +: 8] = mask_reg;
      assign running_w[i] = counting;
    end
  endgenerate

  // --------------------------------------------------------------------
  // Read data, one cycle after the strobe; unmapped reads return zero
  // --------------------------------------------------------------------
  reg [31:0] rd_next;
  reg [1:0] ci;

  always @* begin
    rd_next = 32'h00000000;
    ci = ch_sel;
    if (addr == `TCB_BLOCK_MODE) begin
      rd_next = {26'h0000000, block_mode_reg};
    end else if (ch_sel != 2'h3) begin
      case (ch_off)
        `TCB_CH_MODE: rd_next = mode_w[32 * ci +: 32];
        `TCB_CH_CV: rd_next = {16'h0000, cv_w[16 * ci +: 16]};
        `TCB_CH_RA: rd_next = {16'h0000, ra_w[16 * ci +: 16]};
        `TCB_CH_RB: rd_next = {16'h0000, rb_w[16 * ci +: 16]};
        `TCB_CH_RC: rd_next = {16'h0000, rc_w[16 * ci +: 16]};
        `TCB_CH_STATUS: begin
          rd_next[7:0] = status_w[8 * ci +: 8];
          rd_next[`TCB_ST_CLKSTA] = running_w[ci];
        end
        `TCB_CH_IRQ_MASK: rd_next = {24'h000000, mask_w[8 * ci +: 8]};
        default: rd_next = 32'h00000000;
      endcase
    end
  end

  always @(posedge clock) begin
    if (!rst_b) begin
      rdata <= 32'h00000000;
      counter_running <= 3'h0;
    end else if (clk_en) begin
      rdata <= rd ? rd_next : 32'h00000000;
      counter_running <= running_w;
    end
  end

endmodule

`default_nettype wire

/* File: rtl/tcb_map.vh */
/*
  Register map, field positions and reset values of the three-channel
  timer block. Definitions only; included by the block's design file.
*/
`ifndef TCB_MAP_VH
`define TCB_MAP_VH

// ----------------------------------------------------------------------
// Global map
// ----------------------------------------------------------------------
`define TCB_CH0_BASE 8'h00
`define TCB_CH1_BASE 8'h40
`define TCB_CH2_BASE 8'h80
`define TCB_BLOCK_CTRL 8'hC0
`define TCB_BLOCK_MODE 8'hC4

// ----------------------------------------------------------------------
// Channel map, relative to the channel base
// ----------------------------------------------------------------------
`define TCB_CH_CMD 6'h00
`define TCB_CH_MODE 6'h04
`define TCB_CH_CV 6'h10
`define TCB_CH_RA 6'h14
`define TCB_CH_RB 6'h18
`define TCB_CH_RC 6'h1C
`define TCB_CH_STATUS 6'h20
`define TCB_CH_IRQ_EN 6'h24
`define TCB_CH_IRQ_DIS 6'h28
`define TCB_CH_IRQ_MASK 6'h2C

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define TCB_BCR_SYNC 0
`define TCB_CCR_CLOCK_ENABLE_CMD 0
`define TCB_CCR_CLOCK_DISABLE_CMD 1
`define TCB_CCR_SOFTWARE_TRIGGER_CMD 2
`define TCB_CMR_CLOCK_INVERT 3
`define TCB_CMR_STOP_ON_B_LOAD 6
`define TCB_CMR_DISABLE_ON_B_LOAD 7
`define TCB_CMR_EXT_TRIGGER_SOURCE 10
`define TCB_CMR_COMPARE_C_TRIGGER 14
`define TCB_CMR_WAVE 15
`define TCB_CMR_RESET 32'h00000000
`define TCB_BMR_RESET 6'h00
`define TCB_ST_OVF 0
`define TCB_ST_LOVR 1
`define TCB_ST_CPC 4
`define TCB_ST_LDA 5
`define TCB_ST_LDB 6
`define TCB_ST_ETRG 7
`define TCB_ST_CLKSTA 16
`define TCB_EDGE_NONE 2'h0
`define TCB_EDGE_RISE 2'h1
`define TCB_EDGE_FALL 2'h2
`define TCB_EDGE_BOTH 2'h3
`define TCB_SRC_NONE 2'h1

`endif

/* File: verification/tcb_chk.sv */
/*
  Checker for the timer block: read data timing, block mode read-back,
  external clock line routing and counter run state of channel 0.
  Assumes clk_en stays high while the checker is bound to the block.
*/
`timescale 1ns/1ps
`default_nettype none
module tcb_chk (
  // Clock and control
  input wire clock,
  input wire rst_b,
  input wire clk_en,
  // Register port
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  input wire [31:0] rdata,
  // Timer pins and observed state
  input wire [4:0] internal_clock,
  input wire [2:0] clock_pin,
  input wire [2:0] channel_line_a,
  input wire [2:0] channel_line_b,
  input wire [2:0] external_clock_line,
  input wire [2:0] counter_running
);
  // ----------------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------------
  logic [5:0] bmr_reg;
  logic [2:0] calm_reg;
  logic [2:0] pin_reg [3];
  logic [2:0] la_reg [3];
  logic [2:0] exp_line;
  // The pipes copy the block's sync plus output flop, so routing is judged
  // only once the selector and the pipes have settled.
  always @(posedge clock) begin
    pin_reg[0] <= clock_pin;
    pin_reg[1] <= pin_reg[0];
    pin_reg[2] <= pin_reg[1];
    la_reg[0] <= channel_line_a;
    la_reg[1] <= la_reg[0];
    la_reg[2] <= la_reg[1];
    if (!rst_b) begin
      bmr_reg <= 6'h00;
    end else if (wr && addr == 8'hC4) begin
      bmr_reg <= wdata[5:0];
    end
    if (!rst_b || !clk_en || (wr && addr == 8'hC4)) begin
      calm_reg <= 3'h0;
    end else if (calm_reg != 3'h7) begin
      calm_reg <= calm_reg + 3'h1;
    end
  end
  function automatic logic pick(input logic [1:0] c, input logic p, input logic x,
                                input logic y);
    pick = (c == 2'h0) ? p : (c == 2'h1) ? 1'b0 : (c == 2'h2) ? x : y;
  endfunction
  assign exp_line = {pick(bmr_reg[5:4], pin_reg[2][2], la_reg[2][0], la_reg[2][1]),
                     pick(bmr_reg[3:2], pin_reg[2][1], la_reg[2][0], la_reg[2][2]),
                     pick(bmr_reg[1:0], pin_reg[2][0], la_reg[2][1], la_reg[2][2])};
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_rd_idle; !rd |=> rdata == 32'h0; endproperty
  property p_bmr_back;
    logic [5:0] v;
    (wr && addr == 8'hC4, v = wdata[5:0]) ##2 (rd && addr == 8'hC4) |=> rdata == {26'h0, v};
  endproperty
  property p_line0; calm_reg >= 3'h4 |-> external_clock_line[0] == exp_line[0]; endproperty
  property p_line1; calm_reg >= 3'h4 |-> external_clock_line[1] == exp_line[1]; endproperty
  property p_line2; calm_reg >= 3'h4 |-> external_clock_line[2] == exp_line[2]; endproperty
  property p_enable; wr && addr == 8'h00 && wdata[2:0] == 3'h5 |-> ##2 counter_running[0];
  endproperty
  property p_disable; wr && addr == 8'h00 && wdata[1] |-> ##2 !counter_running[0]; endproperty
  property p_wo_zero; rd && (addr == 8'hC0 || addr[5:0] == 6'h24) |=> rdata == 32'h0;
  endproperty
  property p_unmapped; rd && addr > 8'hC4 |=> rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  a_bmr_back: assert property (p_bmr_back) else $error("block mode lost");
  a_line0: assert property (p_line0) else $error("line 0 routing wrong");
  a_line1: assert property (p_line1) else $error("line 1 routing wrong");
  a_line2: assert property (p_line2) else $error("line 2 routing wrong");
  a_enable: assert property (p_enable) else $error("clock did not start");
  a_disable: assert property (p_disable) else $error("clock did not stop");
  a_wo_zero: assert property (p_wo_zero) else $error("write-only place read");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  c_route: cover property (calm_reg >= 3'h4 && bmr_reg[1:0] == 2'h2);
  c_all_run: cover property (counter_running == 3'h7);
  c_rd_a: cover property (rd && addr == 8'h14);
endmodule
bind tcb_top tcb_chk u_chk (.clock, .rst_b, .clk_en, .addr, .wdata, .wr, .rd, .rdata,
  .internal_clock, .clock_pin, .channel_line_a, .channel_line_b, .external_clock_line,
  .counter_running);
`default_nettype wire

/* File: verification/tcb_pins.sv */
/*
  Far-side model: free-running timer clocks, clock pins and channel lines.
  Assumes the bench asks for pin and line levels through the lvl inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module tcb_pins (
  // Clock
  input wire logic clock,
  // Levels asked for by the bench
  input wire logic [2:0] lvl_pin,
  input wire logic [2:0] lvl_a,
  input wire logic [2:0] lvl_b,
  // Lines seen by the block
  output logic [4:0] internal_clock,
  output logic [2:0] clock_pin,
  output logic [2:0] channel_line_a,
  output logic [2:0] channel_line_b
);
  logic [7:0] div_reg = 8'h00;
  logic [8:0] lvl_reg = 9'h000;
  // Lines change only after a clock edge, so every level lasts whole cycles.
  always @(posedge clock) begin
    div_reg <= div_reg + 8'h01;
    lvl_reg <= {lvl_b, lvl_a, lvl_pin};
  end
  assign internal_clock = div_reg[6:2];
  assign {channel_line_b, channel_line_a, clock_pin} = lvl_reg;
endmodule
`default_nettype wire

/* File: verification/tb_tcb_top.sv */
/*
  Self-checking bench for the timer block: map, access kinds, routing,
  run control, triggers and captures. Assumes tcb_pins drives the lines.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_tcb_top;
  logic clock, rst_b, clk_en, wr, rd;
  logic [7:0] addr, base;
  logic [31:0] wdata, rdata, d, v;
  logic [4:0] internal_clock;
  logic [2:0] clock_pin, channel_line_a, channel_line_b, external_clock_line;
  logic [2:0] counter_running, lvl_pin, lvl_a, lvl_b, e;
  int errors = 0, checks = 0, ch, code;
  int unsigned mdl [int];
  logic [7:0] offs [$] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
    8'h20, 8'h24, 8'h28, 8'h2C, 8'h3C, 8'hC0, 8'hC4, 8'hC8, 8'hFC};
  tcb_top dut (.clock, .rst_b, .clk_en, .addr, .wdata, .wr, .rd, .rdata, .internal_clock,
    .clock_pin, .channel_line_a, .channel_line_b, .external_clock_line, .counter_running);
  tcb_pins pins (.clock, .lvl_pin, .lvl_a, .lvl_b, .internal_clock, .clock_pin,
    .channel_line_a, .channel_line_b);
  // ----------------------------------------------------------------------
  // Bus tasks, comparison and verdict
  // ----------------------------------------------------------------------
  task automatic wreg(input logic [7:0] a, input logic [31:0] x);
    @(posedge clock);
    addr <= a;
    wdata <= x;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    mdl[a] = x;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] x);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    x = rdata;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    if (errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [2:0] route(input int c, input logic [2:0] p, input logic [2:0] a);
    route = (c == 0) ? p : (c == 1) ? 3'h0 : (c == 2) ? {a[0], a[0], a[1]} : {a[1], a[2], a[2]};
  endfunction
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    report_and_stop();
  end
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(32'h3863d14e));
    rst_b = 1'b0;
    clk_en = 1'b1;
    {wr, rd, addr, wdata, lvl_pin, lvl_a, lvl_b} = '0;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    foreach (offs[i]) begin
      rreg(offs[i], d);
      chk(d, 32'h0);
    end
    for (ch = 0; ch < 3; ch++) begin
      base = 8'(ch * 64);
      rreg(base + 8'h04, d);
      chk(d, 32'h0);
      v = $urandom & 32'h000F47FF;
      wreg(base + 8'h04, v);
      rreg(base + 8'h04, d);
      chk(d & 32'h000FC7FF, mdl[base + 8'h04]);
      wreg(base + 8'h1C, $urandom & 32'hFFFF);
      rreg(base + 8'h1C, d);
      chk(d, mdl[base + 8'h1C]);
      wreg(base + 8'h14, 32'h1234);
      rreg(base + 8'h14, d);
      chk(d, 32'h0);
      wreg(base + 8'h04, 32'h8000);
      wreg(base + 8'h18, v & 32'hFFFF);
      rreg(base + 8'h18, d);
      chk(d, v & 32'hFFFF);
      wreg(base + 8'h04, 32'h0);
      wreg(base + 8'h24, 32'hFF);
      wreg(base + 8'h28, 32'h0F);
      wreg(base + 8'h24, 32'h0);
      rreg(base + 8'h2C, d);
      chk(d, 32'hF0);
      wreg(base + 8'h28, 32'hF0);
    end
    for (code = 0; code < 4; code++) begin
      wreg(8'hC4, {code[1:0], code[1:0], code[1:0]});
      rreg(8'hC4, d);
      chk(d, mdl[8'hC4]);
      lvl_pin <= 3'($urandom);
      lvl_a <= 3'($urandom);
      repeat (7) @(posedge clock);
      #1;
      e = route(code, lvl_pin, lvl_a);
      chk(external_clock_line, e);
    end
    wreg(8'hC4, 32'h0);
    lvl_a <= 3'h0;
    wreg(8'h00, 32'h5);
    repeat (100) @(posedge clock);
    rreg(8'h10, d);
    chk(d >= 32'h8 && d <= 32'hE, 32'h1);
    wreg(8'h00, 32'h3);
    rreg(8'h10, d);
    repeat (40) @(posedge clock);
    rreg(8'h10, v);
    chk(v, d);
    wreg(8'h00, 32'h5);
    repeat (20) @(posedge clock);
    rreg(8'h10, d);
    chk(d <= 32'h3 && counter_running[0], 32'h1);
    wreg(8'h1C, 32'h4);
    wreg(8'h04, 32'h4000);
    repeat (8) begin
      repeat (5) @(posedge clock);
      rreg(8'h10, d);
      chk(d <= 32'h5, 32'h1);
    end
    wreg(8'h04, 32'h00090080);
    wreg(8'h00, 32'h5);
    repeat (40) @(posedge clock);
    lvl_a[0] <= 1'b1;
    repeat (40) @(posedge clock);
    lvl_a[0] <= 1'b0;
    repeat (12) @(posedge clock);
    chk(counter_running[0], 1'b0);
    lvl_a[0] <= 1'b1;
    repeat (12) @(posedge clock);
    rreg(8'h20, d);
    chk(d & 32'h62, 32'h62);
    rreg(8'h18, d);
    chk(d >= 32'h6 && d <= 32'hC, 32'h1);
    wreg(8'h04, 32'h0);
    for (ch = 0; ch < 3; ch++) wreg(8'(ch * 64), 32'h1);
    repeat (80) @(posedge clock);
    wreg(8'hC0, 32'h1);
    repeat (16) @(posedge clock);
    for (ch = 0; ch < 3; ch++) begin
      rreg(8'(ch * 64 + 16), d);
      chk(d <= 32'h3, 32'h1);
    end
    wreg(8'h44, 32'h100);
    repeat (80) @(posedge clock);
    lvl_b[1] <= 1'b1;
    repeat (16) @(posedge clock);
    rreg(8'h50, d);
    chk(d <= 32'h3, 32'h1);
    // Channel 2 counts pin 0 through line 0: plain, then inverted and gated by line 2.
    for (code = 0; code < 2; code++) begin
      wreg(8'h80, 32'h2);
      lvl_pin <= 3'h0;
      repeat (8) @(posedge clock);
      wreg(8'h84, code ? 32'h3D : 32'h5);
      repeat (8) @(posedge clock);
      wreg(8'h80, 32'h5);
      repeat (8) @(posedge clock);
      for (ch = 0; ch < 5; ch++) begin
        repeat (3) @(posedge clock);
        lvl_pin[2] <= (code == 1 && ch >= 2);
        repeat (3) @(posedge clock);
        lvl_pin[0] <= 1'b1;
        repeat (6) @(posedge clock);
        if (ch < 4) lvl_pin[0] <= 1'b0;
      end
      repeat (8) @(posedge clock);
      rreg(8'h90, d);
      chk(d, code ? 32'h1 : 32'h4);
    end
    wreg(8'h44, 32'h00050040);
    wreg(8'h40, 32'h5);
    repeat (2) begin
      repeat (20) @(posedge clock);
      lvl_a[1] <= 1'b1;
      repeat (20) @(posedge clock);
      lvl_a[1] <= 1'b0;
    end
    repeat (8) @(posedge clock);
    #1;
    chk(counter_running[1], 1'b0);
    wreg(8'h44, 32'h00000600);
    lvl_a[1] <= 1'b1;
    repeat (20) @(posedge clock);
    lvl_a[1] <= 1'b0;
    repeat (20) @(posedge clock);
    #1;
    chk(counter_running[1], 1'b1);
    rreg(8'h50, d);
    chk(d <= 32'h3, 32'h1);
    rst_b <= 1'b0;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    #1;
    chk(counter_running, 3'h0);
    rreg(8'h44, d);
    chk(d, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
